/* File: hdl/eipc_irq_pin.sv */
/*
  External request pin conditioning with its APB control byte.
  Assumes the pin is asynchronous and service comes from the interrupt logic.
*/
// Implementation choices: the APB interface to the registers and the address map.
`include "eipc_params.svh"
module eipc_irq_pin (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [11:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic irq_pin_in,
  input wire logic special_mode_in,
  input wire logic irq_service_in,
  output logic irq_request_out
);
  // Pin synchroniser and filtered level
  logic [2:0] sync;
  logic [2:0] next_sync;
  logic pin_stable;
  logic next_pin_stable;
  // Control byte, edge request and outgoing request
  eipc_pkg::eipc_ctrl_s ctrl;
  eipc_pkg::eipc_ctrl_s next_ctrl;
  logic pending;
  logic next_pending;
  logic req;
  logic next_req;
  // Bus response registers
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic ready;
  logic next_ready;
  logic err;
  logic next_err;
  // Decoded bus strobes and pin event
  logic acc;
  logic sel_ctrl;
  logic sel_stat;
  logic wr_ctrl;
  logic fall;

  // Pin synchroniser; only stage 2 and 3 agreeing counts as a change
  always_comb begin
    next_sync = {sync[1:0], irq_pin_in};
    next_pin_stable = pin_stable;
    if (sync[1] == sync[2]) begin
      next_pin_stable = sync[2];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sync <= 3'h7;
      pin_stable <= 1'b1;
    end else begin
      sync <= next_sync;
      pin_stable <= next_pin_stable;
    end
  end

  // Access phase of APB; answers in the second access cycle
  // Registered ready masks the second access cycle, so a held request
  // is taken once only
  assign acc = psel_in & penable_in & ~ready;

  // Address decode; anything else is unmapped and answers with an error
  always_comb begin
    sel_ctrl = 1'b0;
    sel_stat = 1'b0;
    if (paddr_in == `EIPC_CTRL_ADDR) begin
      sel_ctrl = 1'b1;
    end else if (paddr_in == `EIPC_STAT_ADDR) begin
      sel_stat = 1'b1;
    end
  end

  // Only byte lane 0 carries the control byte
  assign wr_ctrl = acc & pwrite_in & pstrb_in[0] & sel_ctrl;
  // Falling edge of filtered pin, gated by the connect bit
  assign fall = pin_stable & ~next_pin_stable & ctrl.connect;

  // Control byte; edge-select locks after the first normal-mode write
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl.connect = pwdata_in[`EIPC_CONN_BIT];
      if (special_mode_in) begin
        next_ctrl.edge_sel = pwdata_in[`EIPC_EDGE_BIT];
      end else if (!ctrl.locked) begin
        next_ctrl.edge_sel = pwdata_in[`EIPC_EDGE_BIT];
        next_ctrl.locked = 1'b1;
      end
    end
  end

  // Lock only clears on reset; software has no way to reopen it
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ctrl.edge_sel <= `EIPC_EDGE_RST;
      ctrl.connect <= `EIPC_CONN_RST;
      ctrl.locked <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Edge request latch; service clears, a fresh edge in that cycle wins
  // Level mode drops the latch so a later switch starts clean
  always_comb begin
    next_pending = pending;
    if (irq_service_in || !ctrl.edge_sel) begin
      next_pending = 1'b0;
    end
    if (fall && ctrl.edge_sel) begin
      next_pending = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pending <= 1'b0;
    end else begin
      pending <= next_pending;
    end
  end

  // Outgoing request; level mode follows the filtered pin while connected
  always_comb begin
    if (ctrl.edge_sel) begin
      next_req = next_pending;
    end else begin
      next_req = ctrl.connect & ~next_pin_stable;
    end
  end

  // Registered so the interrupt logic never sees a decode glitch
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      req <= 1'b0;
    end else begin
      req <= next_req;
    end
  end

  // Response: one wait state, error for unmapped or read-only targets
  // No error for a refused edge-select write; software reads back instead
  always_comb begin
    next_ready = acc;
    next_err = 1'b0;
    if (acc) begin
      if (sel_stat && pwrite_in) begin
        next_err = 1'b1; // Status is read-only
      end else if (!sel_ctrl && !sel_stat) begin
        next_err = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ready <= 1'b0;
      err <= 1'b0;
    end else begin
      ready <= next_ready;
      err <= next_err;
    end
  end

  // Read mux; reserved and unused bits read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (acc && !pwrite_in) begin
      if (sel_ctrl) begin
        next_rdata[`EIPC_EDGE_BIT] = ctrl.edge_sel;
        next_rdata[`EIPC_CONN_BIT] = ctrl.connect;
      end else if (sel_stat) begin
        next_rdata[`EIPC_PEND_BIT] = pending;
        next_rdata[`EIPC_LVL_BIT] = pin_stable;
      end
    end
  end

  // Data stands for the ready cycle only, zero otherwise
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Every output straight from its flip-flop
  assign prdata_out = rdata;
  assign pready_out = ready;
  assign pslverr_out = err;
  assign irq_request_out = req;
endmodule

/* File: hdl/eipc_params.svh */
/*
  Constants for the external request pin conditioning block.
  Assumes a single 50 MHz clock and an APB slave with 32-bit data.
  How it works, in short:
*/
// How it works
// - Edge mode: only falling pin edges raise a request; steady low ignored.
// - Level mode: a low pin level requests while it lasts.
// - Edge request stays pending until reset, service or level-mode select; pin rising does not clear.
// - Normal/emulation modes: edge-select readable, only first write after reset.
// - Special modes: edge-select freely readable and writable.
// - Connect bit, freely accessible, couples the pin in; clear isolates it.
`ifndef EIPC_PARAMS_SVH
`define EIPC_PARAMS_SVH
`define EIPC_CTRL_ADDR 12'h000
`define EIPC_STAT_ADDR 12'h004
`define EIPC_EDGE_BIT 7
`define EIPC_CONN_BIT 6
`define EIPC_PEND_BIT 0
`define EIPC_LVL_BIT 1
`define EIPC_EDGE_RST 1'b0
`define EIPC_CONN_RST 1'b1
`endif

/* File: hdl/eipc_pkg.sv */
/*
  Types for the external request pin conditioning block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package eipc_pkg;
  typedef struct packed {
    logic edge_sel;
    logic connect;
    logic locked;
  } eipc_ctrl_s;
endpackage

/* File: tb/eipc_pin_src.sv */
/* Source model driving the request pin.
   Assumes the bench clock; idles high. */
module eipc_pin_src (
  input wire logic clk_in,
  input wire logic low_in,
  output logic pin_out = 1'b1
);
  // Moves just after an edge, as a real source
  always @(posedge clk_in) pin_out <= !low_in;
endmodule

/* File: tb/eipc_chk.sv */
/* Port checker for the pin block.
   Assumes one clock; bound below. */
module eipc_chk (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [11:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic special_mode_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic irq_pin_in,
  input wire logic irq_service_in,
  input wire logic irq_request_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // Access phase still waiting for its answer
  wire acc = psel_in & penable_in & !pready_out;
  // Shadow of the control byte, rebuilt from bus writes by the rules
  logic sh_edge, sh_conn, sh_lock;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sh_edge <= 1'b0;
      sh_conn <= 1'b1;
      sh_lock <= 1'b0;
    end else if (acc && pwrite_in && pstrb_in[0] && paddr_in == 12'h000) begin
      sh_conn <= pwdata_in[6];
      if (special_mode_in || !sh_lock) begin
        sh_edge <= pwdata_in[7];
      end
      sh_lock <= sh_lock | !special_mode_in;
    end
  end
  ready_wait_a: assert property (acc |=> pready_out) else $error("late");
  rsvd_zero_a: assert property (
    acc && !pwrite_in && paddr_in == 12'h000 |=> prdata_out[5:0] == 6'h00)
    else $error("rsvd");
  req_cause_a: assert property (
    $rose(irq_request_out) |-> !$past(irq_pin_in, 3)) else $error("cause");
  pend_hold_a: assert property (
    sh_edge && $past(sh_edge) && irq_request_out && !irq_service_in |=>
    irq_request_out) else $error("hold");
  lvl_follow_a: assert property (
    (!sh_edge && sh_conn && !irq_pin_in) [*5] |=> irq_request_out)
    else $error("level");
  iso_quiet_a: assert property (
    !sh_conn && !irq_request_out |=> !irq_request_out)
    else $error("isolated");
  ctrl_read_a: assert property (
    acc && !pwrite_in && paddr_in == 12'h000 |=>
    prdata_out[7:6] == {sh_edge, sh_conn}) else $error("ctrl");
  cover property ($rose(irq_request_out));
  cover property (irq_service_in && irq_request_out);
  cover property (acc && pwrite_in);
endmodule
bind eipc_irq_pin eipc_chk chk (.*);

/* File: tb/testbench.sv */
/* Bench for the pin block.
   Assumes a one wait state APB slave. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic c = 0, r = 1, s = 0, n = 0, w = 0, lo = 0, sp = 0, sv = 0;
  logic p, q, y, e, ev;
  logic [11:0] a = 0;
  logic [31:0] d = 0, rd, v, wv;
  int failures = 0, check_count = 0, t = 0;
  eipc_irq_pin dut (.core_clk_in(c), .reset_in(r), .paddr_in(a),
    .psel_in(s), .penable_in(n), .pwrite_in(w), .pwdata_in(d),
    .pstrb_in(4'hF), .prdata_out(rd), .pready_out(y), .pslverr_out(e),
    .irq_pin_in(p), .special_mode_in(sp), .irq_service_in(sv),
    .irq_request_out(q));
  eipc_pin_src src (.clk_in(c), .low_in(lo), .pin_out(p));
  // Clock, and a cycle ceiling against hangs
  initial forever #10 c = ~c;
  always @(posedge c) if (++t == 3000) begin
    failures++;
    stop_test;
  end
  task automatic cmp(string m, logic [31:0] x, logic [31:0] g);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("[ERR] %s exp %h got %h", m, x, g);
    end
  endtask
  // One APB transfer, held until pready is sampled
  task automatic bus(logic wr, logic [11:0] ad, logic [31:0] wd);
    @(posedge c);
    {s, w, a, d} <= {1'b1, wr, ad, wd};
    @(posedge c);
    n <= 1;
    do @(posedge c); while (!y);
    v = rd;
    ev = e;
    {s, n} <= 2'b00;
  endtask
  function automatic logic [31:0] ctl(logic ed, logic cn);
    return {24'h0, ed, cn, 6'h00};
  endfunction
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(23));
    repeat (12) @(posedge c);
    r <= 0;
    bus(0, 12'h000, 0);
    cmp("ctrl", ctl(0, 1), v);
    lo <= 1;
    repeat (8) @(posedge c);
    cmp("lvl", 1, q);
    lo <= 0;
    repeat (8) @(posedge c);
    cmp("lvl", 0, q);
    bus(1, 12'h000, ctl(1, 0));
    lo <= 1;
    repeat (8) @(posedge c);
    cmp("off", 0, q);
    lo <= 0;
    bus(1, 12'h000, ctl(0, 1));
    bus(0, 12'h000, 0);
    cmp("once", ctl(1, 1), v);
    lo <= 1;
    repeat (8) @(posedge c);
    lo <= 0;
    repeat (8) @(posedge c);
    cmp("pend", 1, q);
    bus(0, 12'h004, 0);
    cmp("stat", 32'h0000_0003, v);
    lo <= 1;
    repeat (8) @(posedge c);
    sv <= 1;
    @(posedge c);
    sv <= 0;
    repeat (10) @(posedge c);
    cmp("edge", 0, q);
    $display("pin tests done");
    // Mid-run reset with the pin released; the lock must reopen
    {lo, r} <= 2'b01;
    repeat (4) @(posedge c);
    r <= 0;
    bus(0, 12'h000, 0);
    cmp("rst", ctl(0, 1), v);
    bus(1, 12'h000, ctl(1, 1));
    bus(1, 12'h000, ctl(0, 1));
    bus(0, 12'h000, 0);
    cmp("relock", ctl(1, 1), v);
    {lo, sp} <= 2'b01;
    for (int i = 0; i < 4; i++) begin
      wv = i ? $urandom : 32'hFFFFFF3F;
      bus(1, 12'h000, wv);
      bus(0, 12'h000, 0);
      cmp("spec", ctl(wv[7], wv[6]), v);
    end
    bus(0, 12'h008, 0);
    cmp("slverr", 1, ev);
    bus(1, 12'h004, 32'h0000_0003);
    cmp("rdonly", 1, ev);
    $display("register tests done");
    stop_test;
  end
endmodule
